// ==== inc/cmr_pkg.sv ====
// package: offsets, fields, codes and pin carriers of the camera link command registers
// Function
// - control upper half ignores writes, reads zero
// - command upper half ignores writes, reads zero
// - command word: write index/code, read status/code
// - command write sets pending flag bit 15
// - acknowledged reset or stream end clears pending
// - store-data write or fetch-data read clears pending
// - power loss or disconnect sets pending
// - watchdog sets timeout after 64/128/1024 link cycles
// - unpowered remote sets timeout flag
// - command write clears timeout flag while remote powered
// - whole written command word goes over link
// - readback hides command bits 15 and 14
// - decode reset, stream end, stream to/from
// - codes 010/011 store or fetch remote register
// - idle codes only sent over link
// - data port at every even index 1008h-1FFEh
// - control bit 0 set disables watchdog
// - control bit 1 switches remote power on
`default_nettype none
package cmr_pkg;
	localparam int          CMR_ADDR_W     = 16;
	localparam int          CMR_WORD_W     = 16;
	localparam int          CMR_WD_W       = 11;
	localparam logic [13:0] IDX_CTL        = 14'h1000;
	localparam logic [13:0] IDX_CTL_RSVD   = 14'h1002;
	localparam logic [13:0] IDX_CMD        = 14'h1004;
	localparam logic [13:0] IDX_CMD_RSVD   = 14'h1006;
	localparam logic [13:0] IDX_DATA_FIRST = 14'h1008;
	localparam logic [13:0] IDX_DATA_LAST  = 14'h1FFE;
	localparam logic [13:0] IDX_IRQ_STAT   = 14'h2000;
	localparam logic [13:0] IDX_IRQ_CLR    = 14'h2001;
	localparam logic [13:0] IDX_IRQ_EN     = 14'h2002;
	localparam int          CTL_WD_DIS     = 0;
	localparam int          CTL_PWR_ON     = 1;
	localparam int          CTL_CCLK_ON    = 2;
	localparam int          CTL_ICLK_DIS   = 3;
	localparam int          CTL_WD_SEL     = 8;
	localparam logic [15:0] CTL_IMPL_MASK  = 16'h030F;
	localparam logic [15:0] CTL_RESET      = 16'h0000;
	localparam logic [15:0] CMD_RESET      = 16'h0000;
	localparam logic [15:0] DATA_RESET     = 16'h0000;
	localparam int          CMD_PEND_BIT   = 15;
	localparam int          CMD_TOUT_BIT   = 14;
	localparam logic [10:0] WD_LIM_64      = 11'h040;
	localparam logic [10:0] WD_LIM_128     = 11'h080;
	localparam logic [10:0] WD_LIM_1024    = 11'h400;
	localparam int          IRQ_W          = 3;
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_TOUT       = 1;
	localparam int          IRQ_LOSS       = 2;
	localparam logic [2:0]  IRQ_RESET      = 3'h0;

	typedef enum logic [2:0] {
		CMR_REMOTE_RESET = 3'h0,
		CMR_STREAM_END   = 3'h1,
		CMR_REG_STORE    = 3'h2,
		CMR_REG_FETCH    = 3'h3,
		CMR_STREAM_TO    = 3'h4,
		CMR_IDLE_A       = 3'h5,
		CMR_IDLE_B       = 3'h6,
		CMR_STREAM_FROM  = 3'h7
	} cmr_code_e;

	typedef enum logic [1:0] {
		CMR_SH_IDLE  = 2'h0,
		CMR_SH_WAIT  = 2'h1,
		CMR_SH_SHIFT = 2'h3
	} cmr_shift_state_e;

	typedef struct packed {
		logic clk;
		logic din;
		logic rdy;
		logic detached;
		logic powered;
	} cmr_link_in_s;

	typedef struct packed {
		logic frame;
		logic dout;
		logic power_en;
		logic cable_clk_en;
	} cmr_link_out_s;

	// watchdog limit from the two select bits
	function automatic logic [10:0] cmr_wd_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    return WD_LIM_64;
			2'h1:    return WD_LIM_128;
			default: return WD_LIM_1024;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== hdl/cmr_link_shift.sv ====
// link word engine: waits for remote ready, shifts one word each way, watchdog
`timescale 1ns/1ps
`default_nettype none
module cmr_link_shift #(
	parameter int WORD_W = cmr_pkg::CMR_WORD_W,
	parameter int WD_W   = cmr_pkg::CMR_WD_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              link_rise,
	input  wire logic              start,
	input  wire logic [WORD_W-1:0] tx_word,
	input  wire logic              din,
	input  wire logic              rdy,
	input  wire logic              wd_en,
	input  wire logic [WD_W-1:0]   limit,
	input  wire logic              abort,
	output logic                   busy,
	output logic                   done,
	output logic                   timed_out,
	output logic [WORD_W-1:0]      rx_word,
	output logic                   frame,
	output logic                   dout
);
	import cmr_pkg::*;

	cmr_shift_state_e    state;
	logic [WORD_W-1:0]   shreg;
	logic [4:0]          bit_cnt;
	logic [WD_W-1:0]     wd_cnt;
	logic                wd_hit;
	logic                last_bit;
	logic                active;

	assign active   = (state != CMR_SH_IDLE);
	assign busy     = active;
	assign wd_hit   = active && wd_en && link_rise && (wd_cnt == limit);
	assign last_bit = (state == CMR_SH_SHIFT) && link_rise && (bit_cnt == 5'(WORD_W - 1));
	assign dout     = shreg[WORD_W-1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CMR_SH_IDLE;
		end else if (active && (abort || wd_hit)) begin
			state <= CMR_SH_IDLE;
		end else begin
			unique case (state)
				CMR_SH_IDLE: begin
					if (start)
						state <= CMR_SH_WAIT;
				end
				CMR_SH_WAIT: begin
					if (link_rise && rdy)
						state <= CMR_SH_SHIFT;
				end
				CMR_SH_SHIFT: begin
					if (last_bit)
						state <= CMR_SH_IDLE;
				end
				default: state <= CMR_SH_IDLE;
			endcase
		end
	end

	// shift register: word out msb first, remote bits in lsb
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg   <= '0;
			bit_cnt <= '0;
		end else if (state == CMR_SH_IDLE && start) begin
			shreg   <= tx_word;
			bit_cnt <= '0;
		end else if (state == CMR_SH_SHIFT && link_rise) begin
			shreg   <= {shreg[WORD_W-2:0], din};
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wd_cnt <= '0;
		else if (state == CMR_SH_IDLE)
			wd_cnt <= '0;
		else if (link_rise && wd_cnt != limit)
			wd_cnt <= wd_cnt + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done      <= 1'b0;
			timed_out <= 1'b0;
			rx_word   <= '0;
		end else begin
			done      <= last_bit && !abort && !wd_hit;
			timed_out <= active && (abort || wd_hit);
			if (last_bit)
				rx_word <= {shreg[WORD_W-2:0], din};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frame <= 1'b0;
		else if (active && (abort || wd_hit || last_bit))
			frame <= 1'b0;
		else if (state == CMR_SH_IDLE && start)
			frame <= 1'b1;
	end
endmodule
`default_nettype wire

// ==== hdl/cmr_link_regs.sv ====
// camera link command registers: apb slave, command/data ports, flags, interrupt
`timescale 1ns/1ps
`default_nettype none
module cmr_link_regs (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic [cmr_pkg::CMR_ADDR_W-1:0]  paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire cmr_pkg::cmr_link_in_s           link_in,
	output cmr_pkg::cmr_link_out_s               link_out,
	output logic                                 irq
);
	import cmr_pkg::*;

	function automatic logic in_data_window(input logic [13:0] idx);
		return (idx >= IDX_DATA_FIRST) && (idx <= IDX_DATA_LAST) && !idx[0];
	endfunction

	function automatic logic code_fetches(input logic [2:0] code);
		return (code == CMR_REG_FETCH) || (code == CMR_STREAM_FROM);
	endfunction

	// pin synchronisers
	cmr_link_in_s  sync1;
	cmr_link_in_s  sync2;
	logic          clk_d;
	logic          link_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			clk_d <= 1'b0;
		end else begin
			sync1 <= link_in;
			sync2 <= sync1;
			clk_d <= sync2.clk;
		end
	end

	assign link_rise = sync2.clk && !clk_d;

	// registers
	logic [15:0]      ctl;
	logic [15:0]      cmd;
	logic [15:0]      data;
	logic             pending;
	logic             timeout;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;

	// engine handshake
	logic             start;
	logic [15:0]      tx_word;
	logic             queue_rx;
	logic             rx_cycle;
	logic             cmd_cycle;
	logic             sh_busy;
	logic             sh_done;
	logic             sh_tout;
	logic [15:0]      sh_rx;
	logic             sh_frame;
	logic             sh_dout;
	logic             busy_any;

	// remote state
	logic             unpowered;
	logic             detached;
	logic             loss;
	logic             loss_d;
	logic             loss_evt;

	assign detached  = sync2.detached;
	assign unpowered = !ctl[CTL_PWR_ON] || !sync2.powered;
	assign loss      = detached || !sync2.powered;
	assign loss_evt  = loss && !loss_d;

	// apb decode
	logic [13:0] idx;
	logic        aligned;
	logic        hit_ctl;
	logic        hit_ctl_rsvd;
	logic        hit_cmd;
	logic        hit_cmd_rsvd;
	logic        hit_data;
	logic        hit_stat;
	logic        hit_clr;
	logic        hit_en;
	logic        mapped;
	logic        access;
	logic        stall;
	logic        fin;
	logic        wr_ok;
	logic        rd_ok;
	logic        cmd_wr;
	logic        data_wr;
	logic        data_rd;
	logic [2:0]  code;

	assign idx          = paddr[15:2];
	assign aligned      = (paddr[1:0] == 2'h0);
	assign hit_ctl      = aligned && (idx == IDX_CTL);
	assign hit_ctl_rsvd = aligned && (idx == IDX_CTL_RSVD);
	assign hit_cmd      = aligned && (idx == IDX_CMD);
	assign hit_cmd_rsvd = aligned && (idx == IDX_CMD_RSVD);
	assign hit_data     = aligned && in_data_window(idx);
	assign hit_stat     = aligned && (idx == IDX_IRQ_STAT);
	assign hit_clr      = aligned && (idx == IDX_IRQ_CLR);
	assign hit_en       = aligned && (idx == IDX_IRQ_EN);
	assign mapped       = hit_ctl || hit_ctl_rsvd || hit_cmd || hit_cmd_rsvd
	                      || hit_data || hit_stat || hit_clr || hit_en;
	assign access       = psel && penable;
	assign busy_any     = sh_busy || start || queue_rx || sh_done || sh_tout;
	// command and data accesses wait for the link engine
	assign stall        = access && (hit_cmd || hit_data) && busy_any;
	assign pready       = !stall;
	assign fin          = access && !stall;
	assign pslverr      = fin && !mapped;
	assign wr_ok        = fin && pwrite && mapped;
	assign rd_ok        = fin && !pwrite && mapped;
	assign cmd_wr       = wr_ok && hit_cmd;
	assign data_wr      = wr_ok && hit_data;
	assign data_rd      = rd_ok && hit_data;
	assign code         = cmd[2:0];

	// read mux; reserved halves and clear register read zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (hit_ctl)
				prdata = {16'h0000, ctl};
			else if (hit_cmd)
				prdata = {16'h0000, pending, timeout, cmd[13:0]};
			else if (hit_data)
				prdata = {16'h0000, data};
			else if (hit_stat)
				prdata = {29'h0000_0000, irq_stat};
			else if (hit_en)
				prdata = {29'h0000_0000, irq_en};
		end
	end

	// link control word; only implemented bits are kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl <= CTL_RESET;
		else if (wr_ok && hit_ctl)
			ctl <= pwdata[15:0] & CTL_IMPL_MASK;
	end
	// writes to the reserved halves change nothing

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd <= CMD_RESET;
		else if (cmd_wr)
			cmd <= pwdata[15:0];
	end

	// data port: host writes, fetched remote words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data <= DATA_RESET;
		else if (data_wr)
			data <= pwdata[15:0];
		else if (sh_done && rx_cycle)
			data <= sh_rx;
	end

	// job launcher
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start     <= 1'b0;
			tx_word   <= '0;
			queue_rx  <= 1'b0;
			rx_cycle  <= 1'b0;
			cmd_cycle <= 1'b0;
		end else begin
			start <= 1'b0;
			if (cmd_wr) begin
				// every code goes out whole, idle codes included
				start     <= 1'b1;
				tx_word   <= pwdata[15:0];
				queue_rx  <= code_fetches(pwdata[2:0]);
				rx_cycle  <= 1'b0;
				cmd_cycle <= 1'b1;
			end else if (data_wr && (code == CMR_REG_STORE || code == CMR_STREAM_TO)) begin
				start     <= 1'b1;
				tx_word   <= pwdata[15:0];
				rx_cycle  <= 1'b0;
				cmd_cycle <= 1'b0;
			end else if (data_rd && code == CMR_STREAM_FROM) begin
				// next stream word fetched after each read
				start     <= 1'b1;
				tx_word   <= '0;
				rx_cycle  <= 1'b1;
				cmd_cycle <= 1'b0;
			end else if (sh_done && queue_rx) begin
				start     <= 1'b1;
				tx_word   <= '0;
				queue_rx  <= 1'b0;
				rx_cycle  <= 1'b1;
				cmd_cycle <= 1'b0;
			end else if (sh_tout) begin
				queue_rx <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			loss_d <= 1'b1; // remote starts unpowered: no false loss edge after reset
		else
			loss_d <= loss;
	end

	// pending flag; sets win over clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pending <= 1'b0;
		else if (cmd_wr)
			pending <= 1'b1;
		else if (loss_evt)
			pending <= 1'b1;
		else if (sh_done && cmd_cycle && (code == CMR_REMOTE_RESET || code == CMR_STREAM_END))
			pending <= 1'b0;
		else if ((data_wr && code == CMR_REG_STORE) || (data_rd && code == CMR_REG_FETCH))
			pending <= 1'b0;
	end

	// timeout flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timeout <= 1'b0;
		else if (sh_tout)
			timeout <= 1'b1;
		else if (unpowered)
			timeout <= 1'b1;
		else if (cmd_wr)
			timeout <= 1'b0;
	end

	// interrupt status, clear and enable
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	always_comb begin
		irq_set           = '0;
		irq_set[IRQ_DONE] = sh_done;
		irq_set[IRQ_TOUT] = sh_tout;
		irq_set[IRQ_LOSS] = loss_evt;
		irq_clr           = (wr_ok && hit_clr) ? pwdata[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat <= IRQ_RESET;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_en <= IRQ_RESET;
		else if (wr_ok && hit_en)
			irq_en <= pwdata[IRQ_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((((irq_stat & ~irq_clr) | irq_set)) & irq_en);
	end

	cmr_link_shift #(
		.WORD_W (CMR_WORD_W),
		.WD_W   (CMR_WD_W)
	) u_shift (
		.pclk      (pclk),
		.presetn   (presetn),
		.link_rise (link_rise),
		.start     (start),
		.tx_word   (tx_word),
		.din       (sync2.din),
		.rdy       (sync2.rdy),
		.wd_en     (!ctl[CTL_WD_DIS]),
		.limit     (cmr_wd_limit(ctl[CTL_WD_SEL+1:CTL_WD_SEL])),
		.abort     (detached || unpowered),
		.busy      (sh_busy),
		.done      (sh_done),
		.timed_out (sh_tout),
		.rx_word   (sh_rx),
		.frame     (sh_frame),
		.dout      (sh_dout)
	);

	assign link_out.frame        = sh_frame;
	assign link_out.dout         = sh_dout;
	assign link_out.power_en     = ctl[CTL_PWR_ON];
	assign link_out.cable_clk_en = ctl[CTL_CCLK_ON];
endmodule
`default_nettype wire

// ==== test/cmr_link_regs_assertions.sv ====
// checker: port-level properties of the camera link command registers
`timescale 1ns/1ps
`default_nettype none
module cmr_link_regs_assertions (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic [15:0]             paddr,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire cmr_pkg::cmr_link_in_s   link_in,
	input wire cmr_pkg::cmr_link_out_s  link_out,
	input wire logic                    irq
);
	import cmr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [13:0] fcnt;
	wire acc = psel && penable && pready;
	wire live = link_in.powered && !link_in.detached;
	sequence s_cmd_wr;
		acc && pwrite && paddr == 16'h4010;
	endsequence
	sequence s_ctl_wr;
		acc && pwrite && paddr == 16'h4000;
	endsequence
	// frame length in pclk cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fcnt <= 14'h0;
		else
			fcnt <= link_out.frame ? fcnt + 14'h1 : 14'h0;
	end
	chk_rsvd_zero: assert property (psel && !pwrite && (paddr == 16'h4008 || paddr == 16'h4018) |->
		prdata == 32'h0 && !pslverr) else $error("reserved half not zero");
	chk_unmapped_err: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr == 16'h4024) |->
		pslverr && pready && prdata == 32'h0) else $error("unmapped access not refused");
	chk_window_ok: assert property (psel && penable && paddr >= 16'h4020 && paddr <= 16'h7FF8 &&
		paddr[2:0] == 3'h0 |-> !pslverr) else $error("data window refused");
	chk_pins_follow: assert property (s_ctl_wr |=> link_out.power_en == $past(pwdata[1]) &&
		link_out.cable_clk_en == $past(pwdata[2])) else $error("pins differ from control");
	chk_cmd_sent: assert property (s_cmd_wr ##0 live |-> ##[1:4] link_out.frame)
		else $error("command word not started");
	chk_frame_hold: assert property ($rose(link_out.frame) && live |-> link_out.frame[*8])
		else $error("word frame too short");
	chk_abort_unpwr: assert property (link_out.frame && !link_in.powered |-> ##[1:5] !link_out.frame)
		else $error("unpowered word not aborted");
	chk_wdog_bound: assert property (fcnt < 14'h20D0)
		else $error("word outlived watchdog");
endmodule
`default_nettype wire

// ==== test/cmr_remote_model.sv ====
// remote camera module: gated link clock, ready, msb-first word shifting
`timescale 1ns/1ps
`default_nettype none
module cmr_remote_model (
	input wire cmr_pkg::cmr_link_out_s link_out,
	input wire logic                   stall,
	input wire logic                   detach,
	input wire logic [15:0]            reply,
	output cmr_pkg::cmr_link_in_s      link_in,
	output logic [15:0]                got,
	output int                         nwords
);
	import cmr_pkg::*;
	logic        lclk;
	logic        din;
	logic [15:0] sr;
	int          k;
	assign link_in = '{clk: lclk, din: din, rdy: !stall, detached: detach, powered: link_out.power_en && !detach};
	// link clock runs only inside frames
	initial begin
		lclk = 0;
		din = 0;
		sr = 0;
		got = 0;
		nwords = 0;
		k = 0;
		#3;
		forever begin
			#32;
			if (link_out.frame || lclk)
				lclk = ~lclk;
		end
	end
	always @(posedge lclk) begin
		if (k == 0) begin
			if (!stall)
				k = 1;
		end else begin
			sr = {sr[14:0], link_out.dout};
			k++;
			if (k == 17) begin
				got = sr;
				nwords++;
				k = 0;
			end
		end
	end
	// idle line toggles so stale bits never match
	always @(negedge lclk) din = (k > 0) ? reply[16 - k] : ~din;
	always @(negedge link_out.frame) k = 0;
endmodule
`default_nettype wire

// ==== test/cmr_link_regs_tb.sv ====
// testbench: apb sequences against the camera link command registers
`timescale 1ns/1ps
`default_nettype none
module cmr_link_regs_tb;
	import cmr_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, stall, detach;
	logic [15:0]   paddr, got;
	logic [31:0]   pwdata, prdata, rd;
	cmr_link_in_s  link_in;
	cmr_link_out_s link_out;
	int            nwords, n0, failures, tests_run;
	cmr_link_regs DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_in(link_in), .link_out(link_out), .irq(irq));
	cmr_remote_model far (.link_out(link_out), .stall(stall), .detach(detach), .reply(16'hC3A5),
		.link_in(link_in), .got(got), .nwords(nwords));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// look at the settled answer on the falling edge, complete on the next rise
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 5000);
		rd = prdata;
		er = pslverr;
		if (pready !== 1'b1) begin
			failures++;
			results();
		end
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check(nm, rd, e);
	endtask
	task automatic results;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, stall, detach} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctl", 16'h4000, 32'h0);
		rchk("cmd_unpwr", 16'h4010, 32'h4000);
		apb(16'h4010, 1'b1, 32'h5);
		rchk("cmd_pend", 16'h4010, 32'hC005);
		for (int i = 0; i < 2; i++) begin
			apb(16'h4008 + 16'(16 * i), 1'b1, 32'hFFFFFFFF);
			rchk("rsvd", 16'h4008 + 16'(16 * i), 32'h0);
		end
		rchk("ctl_kept", 16'h4000, 32'h0);
		rchk("cmd_kept", 16'h4010, 32'hC005);
		apb(16'h4024, 1'b0, 32'h0);
		check("odd_err", {31'h0, er}, 32'h1);
		apb(16'h7FF8, 1'b0, 32'h0);
		check("top_ok", {31'h0, er}, 32'h0);
		apb(16'h4000, 1'b1, 32'h6);
		apb(16'h4010, 1'b1, 32'h7FFD);
		rchk("cmd_hide", 16'h4010, 32'hBFFD);
		check("idle_word", {16'h0, got}, 32'h7FFD);
		apb(16'h4010, 1'b1, 32'h12);
		apb(16'h4020, 1'b1, 32'h1234);
		rchk("store", 16'h4010, 32'h12);
		check("store_word", {16'h0, got}, 32'h1234);
		apb(16'h4010, 1'b1, 32'h1B);
		rchk("fetch_pend", 16'h4010, 32'h801B);
		rchk("fetch", 16'h4028, 32'hC3A5);
		rchk("fetch_clr", 16'h4010, 32'h1B);
		n0 = nwords;
		apb(16'h4010, 1'b1, 32'h4);
		for (int i = 0; i < 3; i++)
			apb(16'(16'h4020 + 8 * i), 1'b1, 32'hA500 + i);
		rchk("stream_to", 16'h4010, 32'h8004);
		check("stream_last", {16'h0, got}, 32'hA502);
		check("stream_cnt", nwords - n0, 32'h4);
		apb(16'h4010, 1'b1, 32'h7);
		for (int i = 0; i < 2; i++)
			rchk("stream_from", 16'h4020, 32'hC3A5);
		for (int c = 0; c < 2; c++) begin
			apb(16'h4010, 1'b1, 32'h8 + c);
			rchk("acked", 16'h4010, 32'h8 + c);
		end
		apb(16'h8004, 1'b1, 32'h7);
		apb(16'h8008, 1'b1, 32'h2);
		stall <= 1'b1;
		apb(16'h4010, 1'b1, 32'h5);
		rchk("wdog", 16'h4010, 32'hC005);
		check("irq_on", {31'h0, irq}, 32'h1);
		apb(16'h8008, 1'b1, 32'h0);
		repeat (2) @(posedge pclk);
		check("irq_mask", {31'h0, irq}, 32'h0);
		apb(16'h8008, 1'b1, 32'h2);
		apb(16'h8004, 1'b1, 32'h2);
		repeat (2) @(posedge pclk);
		check("irq_clr", {31'h0, irq}, 32'h0);
		stall <= 1'b0;
		apb(16'h4010, 1'b1, 32'h8);
		rchk("pre_detach", 16'h4010, 32'h8);
		detach <= 1'b1;
		repeat (8) @(posedge pclk);
		rchk("detach", 16'h4010, 32'hC008);
		rchk("loss_stat", 16'h8000, 32'h5);
		detach <= 1'b0;
		results();
	end
endmodule
bind cmr_link_regs cmr_link_regs_assertions chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .link_in(link_in), .link_out(link_out), .irq(irq));
`default_nettype wire
